// [hdl/burst_sram_regs.vh]
`ifndef BURST_SRAM_REGS_VH
`define BURST_SRAM_REGS_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define WORD_W 18
`define ADDR_W 19
`define BURST_LEN 4
`define LOW_BYTE_MSB 8
`define HIGH_BYTE_LSB 9
// ----------------------------------------
// timing
// ----------------------------------------
`define CORE_CLK_MHZ 20
`define IMP_CAL_CYCLES 1024
`define FIFO_DEPTH 16

`endif

// [hdl/pin_sync.v]
`timescale 1ns/1ns
// ----------------------------------------
// two-stage synchroniser, vector wide
// ----------------------------------------
module pin_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// [hdl/word_fifo.v]
`timescale 1ns/1ns
// ----------------------------------------
// flip-flop fifo, valid/ready both sides
// ----------------------------------------
module word_fifo #(
  parameter W = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
        rp_r <= rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// [hdl/burst_sram.v]
`timescale 1ns/1ns
`include "burst_sram_regs.vh"
// Summary of operation
// - storage of 64 locations (low six address bits), each four 18-bit words, sequential order
// - every burst is four words, two input clock periods on its port
// - new requests on a busy port are ignored; bursts never cut
// - read starts on read select low at K rise; data after next K
// - read bursts accepted at most every second K rising edge
// - read data driven only during delivery, released otherwise
// - write select low at K rise; data one period later on K, K#
// - write bursts accepted at most every second K rising edge
// - read and write addresses both taken from shared bus on K rise
// - write data held in write registers, committed later, no wait
// - read started two or more K rises after a write to same address returns newer data
// - byte strobes sampled with each write word on K and K# rises
// - both output clocks high selects K and K# as output timing
// - port selects sampled on K rise only; a read start blocks a write start
// - deselected port first finishes every pending transaction
// - default impedance at start; optimal after 1024 cycles
// - impedance updates never disturb transactions or timing
// - no pll; clocks may stop and resume without restart
// - read words one, three on inverted clock; two, four on true clock
// - low strobe governs bits 0..8, high strobe bits 9..17
// - write select ignored on a K edge starting a read
module burst_sram #(
  parameter ADDR_W = `ADDR_W,
  parameter MEM_LINES = 64,
  parameter IMP_CYCLES = `IMP_CAL_CYCLES
) (
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  input wire k_clk,
  input wire k_clk_n,
  input wire c_clk,
  input wire c_clk_n,
  input wire read_sel_n,
  input wire write_sel_n,
  input wire [ADDR_W-1:0] shared_address_bus,
  input wire [`WORD_W-1:0] wdata,
  input wire low_byte_write_strobe_n,
  input wire high_byte_write_strobe_n,
  output reg [`WORD_W-1:0] rdata,
  output reg rdata_oe,
  output reg impedance_cal_done,
  output reg [1:0] impedance_code
);
  localparam W = `WORD_W;
  localparam LW = 6;
  localparam MW = 2 + ADDR_W + W + 2;
  // read states
  localparam RD_IDLE = 3'b001;
  localparam RD_WAIT = 3'b010;
  localparam RD_SEND = 3'b100;
  // write states
  localparam WR_IDLE = 3'b001;
  localparam WR_GAP = 3'b010;
  localparam WR_TAKE = 3'b100;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [MW-1:0] pins_s;
  wire [3:0] clk_s;
  pin_sync #(.W(4)) u_clk_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({k_clk, k_clk_n, c_clk, c_clk_n}),
    .q(clk_s)
  );
  pin_sync #(.W(MW)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({read_sel_n, write_sel_n, shared_address_bus, wdata,
        high_byte_write_strobe_n, low_byte_write_strobe_n}),
    .q(pins_s)
  );
  wire rsel_n_s = pins_s[MW-1];
  wire wsel_n_s = pins_s[MW-2];
  wire [ADDR_W-1:0] addr_s = pins_s[MW-3 -: ADDR_W];
  wire [W-1:0] wdata_s = pins_s[W+1:2];
  wire [1:0] bw_n_s = pins_s[1:0];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  reg [3:0] clk_d_r;
  reg single_mode_r;
  // no edges until the synchronisers hold real pin values
  reg [1:0] warm_r;
  wire warm = (warm_r == 2'h3);
  wire k_rise = warm & clk_s[3] & ~clk_d_r[3];
  wire kn_rise = warm & clk_s[2] & ~clk_d_r[2];
  wire c_rise = warm & clk_s[1] & ~clk_d_r[1];
  wire cn_rise = warm & clk_s[0] & ~clk_d_r[0];
  // output timing references
  wire out_true = single_mode_r ? k_rise : c_rise;
  wire out_inv = single_mode_r ? kn_rise : cn_rise;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [W-1:0] mem_r [0:MEM_LINES*4-1];
  reg [ADDR_W-1:0] wr_addr_r;
  reg [W-1:0] wbuf_r [0:3];
  reg [1:0] wmask_r [0:3];
  reg wbuf_pend_r;
  reg [1:0] commit_idx_r;
  reg committing_r;

  function [W-1:0] merge;
    input [W-1:0] oldw;
    input [W-1:0] neww;
    input [1:0] bw_n;
    begin
      merge = oldw;
      if (!bw_n[0])
        merge[`LOW_BYTE_MSB:0] = neww[`LOW_BYTE_MSB:0];
      if (!bw_n[1])
        merge[W-1:`HIGH_BYTE_LSB] = neww[W-1:`HIGH_BYTE_LSB];
    end
  endfunction

  function [LW+1:0] line_idx;
    input [ADDR_W-1:0] a;
    input [1:0] b;
    begin
      line_idx = {a[LW-1:0], b};
    end
  endfunction

  // ----------------------------------------
  // read port
  // ----------------------------------------
  reg [2:0] rd_st_r;
  reg [ADDR_W-1:0] rd_addr_r;
  reg [2:0] rd_cnt_r;
  reg rd_k_gap_r;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [W-1:0] fifo_out_data;
  reg [W-1:0] rd_word;
  reg rd_push;
  reg [1:0] rd_push_idx_r;
  reg rd_loading_r;
  wire rd_start = k_rise & ~rsel_n_s & ~rd_k_gap_r
                  & (rd_st_r == RD_IDLE);
  integer gi;

  always @* begin
    rd_word = mem_r[line_idx(rd_addr_r, rd_push_idx_r)];
    if (wbuf_pend_r && wbuf_addr_eq(rd_addr_r))
      rd_word = merge(rd_word, wbuf_r[rd_push_idx_r],
                      wmask_r[rd_push_idx_r]);
    rd_push = rd_loading_r & fifo_in_ready;
  end

  function wbuf_addr_eq;
    input [ADDR_W-1:0] a;
    begin
      wbuf_addr_eq = (a == wr_addr_r);
    end
  endfunction

  // first/third on inverted edge, second/fourth on true edge
  wire rd_slot = (rd_st_r == RD_SEND)
                 & (rd_cnt_r[0] ? out_true : out_inv);
  wire rd_pop = rd_slot & fifo_out_valid;

  word_fifo #(.W(W), .DEPTH(`FIFO_DEPTH), .AW(4)) u_rd_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(rd_word),
    .in_valid(rd_loading_r),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_pop)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      rd_st_r <= RD_IDLE;
      rd_addr_r <= {ADDR_W{1'b0}};
      rd_cnt_r <= 3'h0;
      rd_k_gap_r <= 1'b0;
      rd_loading_r <= 1'b0;
      rd_push_idx_r <= 2'h0;
      rdata <= {W{1'b0}};
      rdata_oe <= 1'b0;
    end else if (ce) begin
      if (k_rise)
        rd_k_gap_r <= rd_start;
      if (rd_push) begin
        rd_push_idx_r <= rd_push_idx_r + 2'h1;
        if (rd_push_idx_r == 2'h3)
          rd_loading_r <= 1'b0;
      end
      case (rd_st_r)
        RD_IDLE: begin
          rdata_oe <= 1'b0;
          if (rd_start) begin
            rd_addr_r <= addr_s;
            rd_st_r <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (k_rise) begin
            // load late: a write ending half a period ago is seen
            rd_loading_r <= 1'b1;
            rd_push_idx_r <= 2'h0;
            rd_cnt_r <= 3'h0;
            rd_st_r <= RD_SEND;
          end
        end
        RD_SEND: begin
          if (rd_pop) begin
            rdata <= fifo_out_data;
            rdata_oe <= 1'b1;
            rd_cnt_r <= rd_cnt_r + 3'h1;
          end else if (rd_cnt_r == 3'h4 && out_inv) begin
            rdata_oe <= 1'b0;
            rd_st_r <= RD_IDLE;
          end
        end
        default: rd_st_r <= RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // write port
  // ----------------------------------------
  reg [2:0] wr_st_r;
  reg [2:0] wr_cnt_r;
  reg [ADDR_W-1:0] wr_cap_addr_r;
  reg [W-1:0] wcap_r [0:3];
  reg [1:0] wcap_m_r [0:3];
  reg wr_k_gap_r;
  wire wr_start = k_rise & ~wsel_n_s & ~wr_k_gap_r & ~rd_start
                  & (wr_st_r == WR_IDLE);
  wire wr_edge = k_rise | kn_rise;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_st_r <= WR_IDLE;
      wr_cnt_r <= 3'h0;
      wr_cap_addr_r <= {ADDR_W{1'b0}};
      wr_k_gap_r <= 1'b0;
      wr_addr_r <= {ADDR_W{1'b0}};
      wbuf_pend_r <= 1'b0;
      committing_r <= 1'b0;
      commit_idx_r <= 2'h0;
    end else if (ce) begin
      if (k_rise)
        wr_k_gap_r <= wr_start;
      case (wr_st_r)
        WR_IDLE: begin
          if (wr_start) begin
            wr_cap_addr_r <= addr_s;
            wr_cnt_r <= 3'h0;
            wr_st_r <= WR_GAP;
          end
        end
        WR_GAP: begin
          if (k_rise) begin
            wcap_r[0] <= wdata_s;
            wcap_m_r[0] <= bw_n_s;
            wr_cnt_r <= 3'h1;
            wr_st_r <= WR_TAKE;
          end
        end
        WR_TAKE: begin
          if (wr_edge) begin
            wcap_r[wr_cnt_r[1:0]] <= wdata_s;
            wcap_m_r[wr_cnt_r[1:0]] <= bw_n_s;
            wr_cnt_r <= wr_cnt_r + 3'h1;
            if (wr_cnt_r == 3'h3)
              wr_st_r <= WR_IDLE;
          end
        end
        default: wr_st_r <= WR_IDLE;
      endcase
      // hand finished burst to write registers, then self-timed commit
      if (wr_st_r == WR_TAKE && wr_edge && wr_cnt_r == 3'h3) begin
        if (committing_r)
          for (gi = 0; gi < 4; gi = gi + 1)
            mem_r[line_idx(wr_addr_r, gi[1:0])] <=
              merge(mem_r[line_idx(wr_addr_r, gi[1:0])],
                    wbuf_r[gi], wmask_r[gi]);
        for (gi = 0; gi < 3; gi = gi + 1) begin
          wbuf_r[gi] <= wcap_r[gi];
          wmask_r[gi] <= wcap_m_r[gi];
        end
        wbuf_r[3] <= wdata_s;
        wmask_r[3] <= bw_n_s;
        wr_addr_r <= wr_cap_addr_r;
        wbuf_pend_r <= 1'b1;
        committing_r <= 1'b1;
        commit_idx_r <= 2'h0;
      end else if (committing_r && !rd_loading_r) begin
        mem_r[line_idx(wr_addr_r, commit_idx_r)] <=
          merge(mem_r[line_idx(wr_addr_r, commit_idx_r)],
                wbuf_r[commit_idx_r], wmask_r[commit_idx_r]);
        commit_idx_r <= commit_idx_r + 2'h1;
        if (commit_idx_r == 2'h3) begin
          committing_r <= 1'b0;
          wbuf_pend_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // clock edges, mode, impedance
  // ----------------------------------------
  reg [10:0] imp_cnt_r;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      clk_d_r <= 4'h0;
      warm_r <= 2'h0;
      single_mode_r <= 1'b0;
      imp_cnt_r <= 11'h000;
      impedance_cal_done <= 1'b0;
      impedance_code <= 2'h0;
    end else if (ce) begin
      clk_d_r <= clk_s;
      if (!warm)
        warm_r <= warm_r + 2'h1;
      single_mode_r <= clk_s[1] & clk_s[0];
      // counts only on K edges, never gates traffic
      if (k_rise && !impedance_cal_done) begin
        imp_cnt_r <= imp_cnt_r + 11'h001;
        if (imp_cnt_r == IMP_CYCLES[10:0] - 11'h001) begin
          impedance_cal_done <= 1'b1;
          impedance_code <= 2'h1;
        end
      end
    end
  end
endmodule

// [dv/burst_sram_properties.sv]
`timescale 1ns/1ns
module burst_sram_properties #(
  parameter IMP_CYCLES = 1024
) (
  input wire core_clk,
  input wire rst_n,
  input wire k_clk,
  input wire read_sel_n,
  input wire [17:0] rdata,
  input wire rdata_oe,
  input wire impedance_cal_done,
  input wire [1:0] impedance_code
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  reg [11:0] kc_r;
  reg [5:0] since_rd_r;
  reg k_d_r;
  always @(posedge core_clk) begin
    k_d_r <= k_clk;
    if (!rst_n)
      kc_r <= 12'h000;
    else if (k_clk && !k_d_r && kc_r != 12'hFFF)
      kc_r <= kc_r + 12'h001;
    if (!rst_n)
      since_rd_r <= 6'h3F;
    else if (!read_sel_n)
      since_rd_r <= 6'h00;
    else if (since_rd_r != 6'h3F)
      since_rd_r <= since_rd_r + 6'h01;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_oe_up;
    $rose(rdata_oe);
  endsequence
  sequence s_burst;
    rdata_oe [*8];
  endsequence
  a_oe_after_read: assert property (s_oe_up |-> since_rd_r <= 6'h14)
    else $error("read data driven without a read");
  a_burst_min_len: assert property (s_oe_up |-> s_burst)
    else $error("read burst cut short");
  a_burst_release: assert property (s_oe_up |-> ##[15:17]
    (!rdata_oe || since_rd_r < 6'h14))
    else $error("read data not released after burst");
  a_word_hold: assert property (($changed(rdata) && rdata_oe) |=>
    ($stable(rdata) || !rdata_oe) [*2])
    else $error("read word held too briefly");
  a_cal_count: assert property (impedance_cal_done |-> kc_r >= IMP_CYCLES)
    else $error("impedance done too early");
  a_cal_sticky: assert property (impedance_cal_done |=> impedance_cal_done)
    else $error("impedance done dropped");
  a_code_match: assert property (impedance_code ==
    (impedance_cal_done ? 2'h1 : 2'h0))
    else $error("impedance code wrong");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
    (!rdata_oe && !impedance_cal_done))
    else $error("outputs not cleared by reset");
endmodule

bind burst_sram burst_sram_properties #(.IMP_CYCLES(IMP_CYCLES)) u_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .k_clk(k_clk),
  .read_sel_n(read_sel_n),
  .rdata(rdata),
  .rdata_oe(rdata_oe),
  .impedance_cal_done(impedance_cal_done),
  .impedance_code(impedance_code)
);

// [dv/burst_ctrl_model.sv]
`timescale 1ns/1ns
module burst_ctrl_model (
  input wire core_clk,
  input wire single,
  output reg k_clk,
  output reg k_clk_n,
  output reg c_clk,
  output reg c_clk_n,
  output reg read_sel_n,
  output reg write_sel_n,
  output reg [18:0] shared_address_bus,
  output reg [17:0] wdata,
  output reg low_byte_write_strobe_n,
  output reg high_byte_write_strobe_n
);
  reg [2:0] ph = 3'h0;
  wire [2:0] nph = ph + 3'h1;
  initial begin
    {k_clk, k_clk_n, c_clk, c_clk_n} = 4'h5;
    {read_sel_n, write_sel_n} = 2'h3;
    {low_byte_write_strobe_n, high_byte_write_strobe_n} = 2'h3;
    shared_address_bus = 19'h00000;
    wdata = 18'h00000;
  end
  // ----------------------------------------
  // free-running clocks, c pair high in single mode
  // ----------------------------------------
  always @(posedge core_clk) begin
    ph <= nph;
    k_clk <= !nph[2];
    k_clk_n <= nph[2];
    c_clk <= single | !nph[2];
    c_clk_n <= single | nph[2];
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // write words from one period after the command, strobes alongside
  task automatic send(input logic [71:0] w, input logic [7:0] bw);
    int i;
    for (i = 0; i < 4; i++) begin
      step(4);
      wdata <= w[18*i +: 18];
      {high_byte_write_strobe_n, low_byte_write_strobe_n} <= bw[2*i +: 2];
    end
    step(4);
    wdata <= ~w[71:54];
    {high_byte_write_strobe_n, low_byte_write_strobe_n} <= 2'h3;
  endtask
  task automatic cmd(input logic rd, input logic wr, input logic hold,
      input logic [18:0] a, input logic [18:0] a2, input logic [71:0] w,
      input logic [7:0] bw);
    do begin
      @(posedge core_clk);
      #1;
    end while (ph != 3'h6);
    @(posedge core_clk);
    read_sel_n <= !rd;
    write_sel_n <= !wr;
    shared_address_bus <= a;
    step(4);
    if (wr)
      fork
        send(w, bw);
      join_none
    if (hold) begin
      shared_address_bus <= a2;
      step(8);
    end
    read_sel_n <= 1'b1;
    write_sel_n <= 1'b1;
    shared_address_bus <= ~shared_address_bus;
    step(4);
  endtask
endmodule

// [dv/tb_burst_sram.sv]
`timescale 1ns/1ns
module tb_burst_sram;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg single = 1'b0;
  reg ce = 1'b1;
  wire k_clk, k_clk_n, c_clk, c_clk_n, rs_n, ws_n, lo_n, hi_n, oe, cal_done;
  wire [18:0] addr;
  wire [17:0] wdata, rdata;
  wire [1:0] code;
  integer n_mismatch = 0;
  integer checked = 0;
  integer cyc = 0;
  logic [71:0] q;
  localparam logic [18:0] A = 19'h00005, B = 19'h0000A, C = 19'h00013;
  localparam logic [71:0] W1 = {18'h30004, 18'h20003, 18'h10002, 18'h00001};
  localparam logic [71:0] Z = {18'h0ABCD, 18'h1BCDE, 18'h2CDEF, 18'h3DEF0};
  always #25 core_clk = ~core_clk;
  burst_ctrl_model m (.core_clk(core_clk), .single(single), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .read_sel_n(rs_n),
    .write_sel_n(ws_n), .shared_address_bus(addr), .wdata(wdata),
    .low_byte_write_strobe_n(lo_n), .high_byte_write_strobe_n(hi_n));
  burst_sram #(.IMP_CYCLES(8)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
    .c_clk_n(c_clk_n), .read_sel_n(rs_n), .write_sel_n(ws_n),
    .shared_address_bus(addr), .wdata(wdata),
    .low_byte_write_strobe_n(lo_n), .high_byte_write_strobe_n(hi_n),
    .rdata(rdata), .rdata_oe(oe), .impedance_cal_done(cal_done),
    .impedance_code(code));
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task chk(input logic [71:0] seen, input logic [71:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic get(output logic [71:0] r);
    int i;
    i = 0;
    while (oe !== 1'b1 && i < 60) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    for (i = 0; i < 4; i++) begin
      r[18*i +: 18] = rdata;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  task rd(input logic [18:0] a);
    m.cmd(1'b1, 1'b0, 1'b0, a, 19'h00000, 72'h0, 8'hFF);
    get(q);
  endtask
  task wr(input logic [18:0] a, input logic [71:0] w, input logic [7:0] bw);
    m.cmd(1'b0, 1'b1, 1'b0, a, 19'h00000, w, bw);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_cal;
    chk(code, 72'h0);
    chk({oe, cal_done}, 72'h0);
    ce <= 1'b0;
    m.step(80);
    chk(cal_done, 72'h0);
    ce <= 1'b1;
    m.step(150);
    chk({cal_done, code}, 72'h5);
    $display("test cal done");
  endtask
  task t_coh;
    wr(A, ~W1, 8'h00);
    m.step(8);
    wr(A, W1, 8'h00);
    rd(A);
    chk(q, W1);
    rd(A);
    chk(q, W1);
    $display("test coherency done");
  endtask
  task t_byte;
    wr(B, {72{1'b1}}, 8'h00);
    m.step(8);
    wr(B, 72'h0, 8'hE4);
    rd(B);
    chk(q, {18'h3FFFF, 18'h3FE00, 18'h001FF, 18'h00000});
    $display("test byte write done");
  endtask
  task t_ignore;
    integer seen;
    m.cmd(1'b1, 1'b0, 1'b1, A, B, 72'h0, 8'hFF);
    get(q);
    chk(q, W1);
    m.step(4);
    seen = 0;
    repeat (24) begin
      @(posedge core_clk);
      if (oe === 1'b1)
        seen = 1;
    end
    chk(seen, 72'h0);
    m.cmd(1'b0, 1'b1, 1'b1, C, A, Z, 8'h00);
    m.step(8);
    rd(A);
    chk(q, W1);
    rd(C);
    chk(q, Z);
    $display("test ignore done");
  endtask
  task t_same;
    m.cmd(1'b1, 1'b1, 1'b0, C, 19'h00000, W1, 8'h00);
    get(q);
    chk(q, Z);
    m.step(8);
    rd(C);
    chk(q, Z);
    $display("test same edge done");
  endtask
  task t_single;
    @(posedge core_clk);
    rst_n <= 1'b0;
    single <= 1'b1;
    m.step(20);
    rst_n <= 1'b1;
    m.step(4);
    chk({oe, cal_done, code}, 72'h0);
    rd(A);
    chk(q, W1);
    $display("test single clock done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    m.step(4);
    t_cal;
    t_coh;
    t_byte;
    t_ignore;
    t_same;
    t_single;
    print_verdict;
  end
endmodule
